/* File: rtl/pfc_top.sv */
// How it works
// - the preamble pair count is ten bits, top two from 0x2B bits 1:0, low eight from 0x2C.
// - bit 7 of 0x2D picks a one byte (0) or two byte (1) length field.
// - bit 3 of 0x2D adds an address field to sent frames and expects one in received frames.
// - bits 7:6 of 0x2E pick basic, 802.15.4g, uart over the air or stack framing.
// - bits 5:4 of 0x2E route receive data to the packet handler, the fifo or a pin.
// - bit 3 of 0x2E swaps the mapping of bit pairs onto the four fsk symbols.
// - bit 2 of 0x2E picks msb first or lsb first bit order.
// - bits 1:0 of 0x2E pick the alternating preamble pattern.
// - bit 5 of 0x2F gives the frame check type written into the 802.15.4g header.
// - bit 4 of 0x2F is the fec code type in 802.15.4g and the stop bit level in uart framing.
// - bit 3 of 0x2F enables interleaving in 802.15.4g and is the start bit level in uart framing.
// - bit 2 of 0x2F turns on 3-out-of-6 coding in both directions.
// - bit 1 of 0x2F turns on manchester coding in both directions.
// - bit 0 of 0x2F picks fixed or variable length, and variable length needs the length width set first.
// - bits 7:5 of 0x30 pick no crc or one of five crc polynomials.
// - bits 7:2 of 0x2B hold the sync field length in bits.
`timescale 1ns/1ns
`default_nettype none

module pfc_top (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output pfc_pkg::pfc_cfg_type cfg_o,
	output logic length_cfg_error_o
);

	// ****************************************
	// helpers
	// ****************************************

	// offset to storage slot, plus hit flag
	function automatic logic [3:0] slot_of(input logic [7:0] addr);
		logic [3:0] r;
		r = 4'h0;
		unique case (addr)
			pfc_pkg::OFS_PREAMBLE_HIGH_SYNC_LENGTH: r = 4'h8;
			pfc_pkg::OFS_PREAMBLE_LENGTH_LOW: r = 4'h9;
			pfc_pkg::OFS_LENGTH_ADDRESS_OPTIONS: r = 4'hA;
			pfc_pkg::OFS_FRAME_FORMAT_RX_PATH: r = 4'hB;
			pfc_pkg::OFS_CODING_LENGTH_OPTIONS: r = 4'hC;
			pfc_pkg::OFS_CRC_AND_TX_OPTIONS: r = 4'hD;
			default: r = 4'h0;
		endcase
		return r;
	endfunction

	// writable mask of a slot
	function automatic logic [7:0] mask_of(input logic [2:0] idx);
		logic [7:0] m;
		m = 8'h00;
		unique case (idx)
			3'h0: m = pfc_pkg::MSK_PREAMBLE_HIGH_SYNC_LENGTH;
			3'h1: m = pfc_pkg::MSK_PREAMBLE_LENGTH_LOW;
			3'h2: m = pfc_pkg::MSK_LENGTH_ADDRESS_OPTIONS;
			3'h3: m = pfc_pkg::MSK_FRAME_FORMAT_RX_PATH;
			3'h4: m = pfc_pkg::MSK_CODING_LENGTH_OPTIONS;
			3'h5: m = pfc_pkg::MSK_CRC_AND_TX_OPTIONS;
			default: m = 8'h00;
		endcase
		return m;
	endfunction

	// ****************************************
	// register storage
	// ****************************************

	logic [7:0] regs_q [pfc_pkg::REG_COUNT];
	logic [3:0] wr_slot;
	logic [3:0] rd_slot;
	pfc_pkg::pfc_cfg_type cfg_d;
	pfc_pkg::pfc_cfg_type cfg_q;
	logic [7:0] r2b;
	logic [7:0] r2c;
	logic [7:0] r2d;
	logic [7:0] r2e;
	logic [7:0] r2f;
	logic [7:0] r30;

	// offset decode and per-offset views of the storage
	assign wr_slot = slot_of(reg_addr_i);
	assign rd_slot = slot_of(reg_addr_i);
	assign r2b = regs_q[0];
	assign r2c = regs_q[1];
	assign r2d = regs_q[2];
	assign r2e = regs_q[3];
	assign r2f = regs_q[4];
	assign r30 = regs_q[5];

	// register writes, reserved bits dropped
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			regs_q[0] <= pfc_pkg::RST_PREAMBLE_HIGH_SYNC_LENGTH;
			regs_q[1] <= pfc_pkg::RST_PREAMBLE_LENGTH_LOW;
			regs_q[2] <= pfc_pkg::RST_LENGTH_ADDRESS_OPTIONS;
			regs_q[3] <= pfc_pkg::RST_FRAME_FORMAT_RX_PATH;
			regs_q[4] <= pfc_pkg::RST_CODING_LENGTH_OPTIONS;
			regs_q[5] <= pfc_pkg::RST_CRC_AND_TX_OPTIONS;
		end else if (reg_wr_i && wr_slot[3]) begin
			regs_q[wr_slot[2:0]] <= reg_wdata_i & mask_of(wr_slot[2:0]);
		end
	end

	// read port, unmapped offsets read zero
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i && rd_slot[3]) begin
				reg_rdata_o <= regs_q[rd_slot[2:0]] & mask_of(rd_slot[2:0]);
			end else begin
				reg_rdata_o <= 8'h00;
			end
		end
	end

	// ****************************************
	// field decode
	// ****************************************

	// framing configuration from stored fields
	always_comb begin
		cfg_d = '0;
		cfg_d.sync_bit_count = r2b[pfc_pkg::POS_SYNC_BIT_COUNT_LSB +: 6];
		cfg_d.preamble_pair_count = {r2b[pfc_pkg::POS_PREAMBLE_HIGH_LSB +: 2], r2c};
		cfg_d.length_field_bytes = r2d[pfc_pkg::POS_LENGTH_FIELD_BYTES];
		cfg_d.address_field_include = r2d[pfc_pkg::POS_ADDRESS_INCLUDE];
		cfg_d.frame_format = r2e[pfc_pkg::POS_FRAME_FORMAT_LSB +: 2];
		cfg_d.rx_path = r2e[pfc_pkg::POS_RX_PATH_LSB +: 2];
		cfg_d.four_level_symbol_map_swap = r2e[pfc_pkg::POS_SYMBOL_SWAP];
		cfg_d.lsb_first = r2e[pfc_pkg::POS_BIT_ORDER];
		cfg_d.preamble_pattern = r2e[pfc_pkg::POS_PREAMBLE_SEL_LSB +: 2];
		cfg_d.frame_check_type_hdr = r2f[pfc_pkg::POS_FRAME_CHECK_TYPE];
		cfg_d.three_of_six_enable = r2f[pfc_pkg::POS_THREE_OF_SIX];
		cfg_d.manchester_enable = r2f[pfc_pkg::POS_MANCHESTER];
		cfg_d.length_mode_variable = r2f[pfc_pkg::POS_LENGTH_VARIABLE];
		// shared bits split by frame format, idle levels otherwise
		if (cfg_d.frame_format == pfc_pkg::FMT_IEEE_4G) begin
			cfg_d.fec_recursive = r2f[pfc_pkg::POS_CODE_OR_STOP];
			cfg_d.interleave_enable = r2f[pfc_pkg::POS_INTERLEAVE_OR_START];
		end
		if (cfg_d.frame_format == pfc_pkg::FMT_UART_OTA) begin
			cfg_d.uart_stop_level = r2f[pfc_pkg::POS_CODE_OR_STOP];
			cfg_d.uart_start_level = r2f[pfc_pkg::POS_INTERLEAVE_OR_START];
		end
		// crc polynomial; codes 6 and 7 behave as no crc
		unique case (r30[pfc_pkg::POS_CRC_MODE_LSB +: 3])
			pfc_pkg::CRC_P8: begin
				cfg_d.crc_enable = 1'b1;
				cfg_d.crc_width = pfc_pkg::WID_P8;
				cfg_d.crc_poly = pfc_pkg::POLY_P8;
			end
			pfc_pkg::CRC_P16A: begin
				cfg_d.crc_enable = 1'b1;
				cfg_d.crc_width = pfc_pkg::WID_P16;
				cfg_d.crc_poly = pfc_pkg::POLY_P16A;
			end
			pfc_pkg::CRC_P16B: begin
				cfg_d.crc_enable = 1'b1;
				cfg_d.crc_width = pfc_pkg::WID_P16;
				cfg_d.crc_poly = pfc_pkg::POLY_P16B;
			end
			pfc_pkg::CRC_P24: begin
				cfg_d.crc_enable = 1'b1;
				cfg_d.crc_width = pfc_pkg::WID_P24;
				cfg_d.crc_poly = pfc_pkg::POLY_P24;
			end
			pfc_pkg::CRC_P32: begin
				cfg_d.crc_enable = 1'b1;
				cfg_d.crc_width = pfc_pkg::WID_P32;
				cfg_d.crc_poly = pfc_pkg::POLY_P32;
			end
			default: begin
				cfg_d.crc_enable = 1'b0;
				cfg_d.crc_width = 6'h00;
				cfg_d.crc_poly = 36'h000000000;
			end
		endcase
	end

	// registered configuration outputs
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_q <= '0;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	assign cfg_o = cfg_q;

	// variable length without two byte width flagged
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			length_cfg_error_o <= 1'b0;
		end else begin
			length_cfg_error_o <= cfg_d.length_mode_variable & ~cfg_d.length_field_bytes;
		end
	end

	// ****************************************
	// checks
	// ****************************************

	preamble_count_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_PREAMBLE_LENGTH_LOW
		|-> ##2 cfg_o.preamble_pair_count[7:0] == $past(reg_wdata_i, 2))
		else $error("preamble low count not applied");

	preamble_high_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_PREAMBLE_HIGH_SYNC_LENGTH
		|-> ##2 cfg_o.preamble_pair_count[9:8] == $past(reg_wdata_i[1:0], 2))
		else $error("preamble high count not applied");

	sync_length_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_PREAMBLE_HIGH_SYNC_LENGTH
		|-> ##2 cfg_o.sync_bit_count == $past(reg_wdata_i[7:2], 2))
		else $error("sync length not applied");

	length_width_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_LENGTH_ADDRESS_OPTIONS
		|-> ##2 cfg_o.length_field_bytes == $past(reg_wdata_i[7], 2)
		&& cfg_o.address_field_include == $past(reg_wdata_i[3], 2))
		else $error("length or address option not applied");

	format_fields_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_FRAME_FORMAT_RX_PATH
		|-> ##2 {cfg_o.frame_format, cfg_o.rx_path, cfg_o.four_level_symbol_map_swap,
		cfg_o.lsb_first, cfg_o.preamble_pattern} == $past(reg_wdata_i, 2))
		else $error("format byte not applied");

	uart_levels_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		cfg_o.frame_format != pfc_pkg::FMT_UART_OTA |-> !cfg_o.uart_stop_level && !cfg_o.uart_start_level)
		else $error("uart level outside uart framing");

	fec_gating_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_CODING_LENGTH_OPTIONS && r2e[7:6] == pfc_pkg::FMT_IEEE_4G
		&& !(reg_wr_i && reg_addr_i == pfc_pkg::OFS_FRAME_FORMAT_RX_PATH)
		##1 !(reg_wr_i && reg_addr_i == pfc_pkg::OFS_FRAME_FORMAT_RX_PATH)
		&& !(reg_wr_i && reg_addr_i == pfc_pkg::OFS_CODING_LENGTH_OPTIONS)
		|-> ##1 cfg_o.fec_recursive == $past(reg_wdata_i[4], 2)
		&& cfg_o.interleave_enable == $past(reg_wdata_i[3], 2))
		else $error("fec options not applied in 802.15.4g");

	coding_bits_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_CODING_LENGTH_OPTIONS
		|-> ##2 cfg_o.three_of_six_enable == $past(reg_wdata_i[2], 2)
		&& cfg_o.manchester_enable == $past(reg_wdata_i[1], 2)
		&& cfg_o.frame_check_type_hdr == $past(reg_wdata_i[5], 2))
		else $error("coding options not applied");

	length_error_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(cfg_o.length_mode_variable) && !cfg_o.length_field_bytes |-> length_cfg_error_o)
		else $error("variable length with one byte width not flagged");

	crc_select_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_CRC_AND_TX_OPTIONS && reg_wdata_i[7:5] == pfc_pkg::CRC_P16A
		|-> ##2 cfg_o.crc_enable && cfg_o.crc_poly == pfc_pkg::POLY_P16A && cfg_o.crc_width == pfc_pkg::WID_P16)
		else $error("crc polynomial select wrong");

	reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_rd_i && reg_addr_i == pfc_pkg::OFS_LENGTH_ADDRESS_OPTIONS |=> (reg_rdata_o & 8'h77) == 8'h00)
		else $error("reserved bits read nonzero");

	// crc select for every code but P16A, which is checked above
	crc_none_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_CRC_AND_TX_OPTIONS
		&& (reg_wdata_i[7:5] == pfc_pkg::CRC_NONE || reg_wdata_i[7:5] > pfc_pkg::CRC_P32)
		|-> ##2 !cfg_o.crc_enable && cfg_o.crc_width == 6'h00 && cfg_o.crc_poly == 36'h000000000)
		else $error("crc not off for codes without a polynomial");

	crc_p8_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_CRC_AND_TX_OPTIONS && reg_wdata_i[7:5] == pfc_pkg::CRC_P8
		|-> ##2 cfg_o.crc_enable && cfg_o.crc_poly == pfc_pkg::POLY_P8 && cfg_o.crc_width == pfc_pkg::WID_P8)
		else $error("crc eight bit select wrong");

	crc_p16b_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_CRC_AND_TX_OPTIONS && reg_wdata_i[7:5] == pfc_pkg::CRC_P16B
		|-> ##2 cfg_o.crc_enable && cfg_o.crc_poly == pfc_pkg::POLY_P16B && cfg_o.crc_width == pfc_pkg::WID_P16)
		else $error("crc second sixteen bit select wrong");

	crc_p24_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_CRC_AND_TX_OPTIONS && reg_wdata_i[7:5] == pfc_pkg::CRC_P24
		|-> ##2 cfg_o.crc_enable && cfg_o.crc_poly == pfc_pkg::POLY_P24 && cfg_o.crc_width == pfc_pkg::WID_P24)
		else $error("crc twenty four bit select wrong");

	crc_p32_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_CRC_AND_TX_OPTIONS && reg_wdata_i[7:5] == pfc_pkg::CRC_P32
		|-> ##2 cfg_o.crc_enable && cfg_o.crc_poly == pfc_pkg::POLY_P32 && cfg_o.crc_width == pfc_pkg::WID_P32)
		else $error("crc thirty two bit select wrong");

	// mode-shared bits of the coding register
	fec_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		cfg_o.frame_format != pfc_pkg::FMT_IEEE_4G
		|-> !cfg_o.fec_recursive && !cfg_o.interleave_enable)
		else $error("fec option outside 802.15.4g framing");

	uart_apply_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == pfc_pkg::OFS_CODING_LENGTH_OPTIONS && r2e[7:6] == pfc_pkg::FMT_UART_OTA
		&& !(reg_wr_i && reg_addr_i == pfc_pkg::OFS_FRAME_FORMAT_RX_PATH)
		##1 !(reg_wr_i && reg_addr_i == pfc_pkg::OFS_FRAME_FORMAT_RX_PATH)
		&& !(reg_wr_i && reg_addr_i == pfc_pkg::OFS_CODING_LENGTH_OPTIONS)
		|-> ##1 cfg_o.uart_stop_level == $past(reg_wdata_i[4], 2)
		&& cfg_o.uart_start_level == $past(reg_wdata_i[3], 2))
		else $error("uart levels not applied in uart framing");

	// defaults decoded one edge after reset release
	reset_decode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(rst_b_i) |-> ##1 cfg_o.preamble_pair_count
		== {pfc_pkg::RST_PREAMBLE_HIGH_SYNC_LENGTH[1:0], pfc_pkg::RST_PREAMBLE_LENGTH_LOW}
		&& cfg_o.sync_bit_count == pfc_pkg::RST_PREAMBLE_HIGH_SYNC_LENGTH[7:2])
		else $error("reset defaults not decoded");

	// ****************************************
	// read port checks
	// ****************************************

	read_answer_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered one cycle later");

	read_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00)
		else $error("read data not cleared without a read");

	unmapped_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_rd_i && !rd_slot[3] |=> reg_rvalid_o && reg_rdata_o == 8'h00)
		else $error("unmapped offset read nonzero");

	reserved_top_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		reg_rd_i && reg_addr_i == pfc_pkg::OFS_CODING_LENGTH_OPTIONS |=> reg_rdata_o[7:6] == 2'h0)
		else $error("reserved coding bits read nonzero");

endmodule // pfc_top

`default_nettype wire

/* File: pkg/pfc_pkg.sv */
// ****************************************
// packet format configuration constants
// ****************************************
package pfc_pkg;

	// register offsets
	localparam logic [7:0] OFS_PREAMBLE_HIGH_SYNC_LENGTH = 8'h2B;
	localparam logic [7:0] OFS_PREAMBLE_LENGTH_LOW = 8'h2C;
	localparam logic [7:0] OFS_LENGTH_ADDRESS_OPTIONS = 8'h2D;
	localparam logic [7:0] OFS_FRAME_FORMAT_RX_PATH = 8'h2E;
	localparam logic [7:0] OFS_CODING_LENGTH_OPTIONS = 8'h2F;
	localparam logic [7:0] OFS_CRC_AND_TX_OPTIONS = 8'h30;
	localparam int REG_COUNT = 6;

	// reset values, in offset order
	localparam logic [7:0] RST_PREAMBLE_HIGH_SYNC_LENGTH = 8'h80;
	localparam logic [7:0] RST_PREAMBLE_LENGTH_LOW = 8'h10;
	localparam logic [7:0] RST_LENGTH_ADDRESS_OPTIONS = 8'h00;
	localparam logic [7:0] RST_FRAME_FORMAT_RX_PATH = 8'h20;
	localparam logic [7:0] RST_CODING_LENGTH_OPTIONS = 8'h00;
	localparam logic [7:0] RST_CRC_AND_TX_OPTIONS = 8'h2C;

	// writable bits; all others read as zero
	localparam logic [7:0] MSK_PREAMBLE_HIGH_SYNC_LENGTH = 8'hFF;
	localparam logic [7:0] MSK_PREAMBLE_LENGTH_LOW = 8'hFF;
	localparam logic [7:0] MSK_LENGTH_ADDRESS_OPTIONS = 8'h88;
	localparam logic [7:0] MSK_FRAME_FORMAT_RX_PATH = 8'hFF;
	localparam logic [7:0] MSK_CODING_LENGTH_OPTIONS = 8'h3F;
	localparam logic [7:0] MSK_CRC_AND_TX_OPTIONS = 8'hFF;

	// field positions
	localparam int POS_SYNC_BIT_COUNT_LSB = 2;
	localparam int POS_PREAMBLE_HIGH_LSB = 0;
	localparam int POS_LENGTH_FIELD_BYTES = 7;
	localparam int POS_ADDRESS_INCLUDE = 3;
	localparam int POS_FRAME_FORMAT_LSB = 6;
	localparam int POS_RX_PATH_LSB = 4;
	localparam int POS_SYMBOL_SWAP = 3;
	localparam int POS_BIT_ORDER = 2;
	localparam int POS_PREAMBLE_SEL_LSB = 0;
	localparam int POS_FRAME_CHECK_TYPE = 5;
	localparam int POS_CODE_OR_STOP = 4;
	localparam int POS_INTERLEAVE_OR_START = 3;
	localparam int POS_THREE_OF_SIX = 2;
	localparam int POS_MANCHESTER = 1;
	localparam int POS_LENGTH_VARIABLE = 0;
	localparam int POS_CRC_MODE_LSB = 5;

	// frame formats
	localparam logic [1:0] FMT_BASIC = 2'h0;
	localparam logic [1:0] FMT_IEEE_4G = 2'h1;
	localparam logic [1:0] FMT_UART_OTA = 2'h2;
	localparam logic [1:0] FMT_STACK = 2'h3;

	// receive data paths
	localparam logic [1:0] RXP_PACKET = 2'h0;
	localparam logic [1:0] RXP_FIFO = 2'h1;
	localparam logic [1:0] RXP_PIN = 2'h2;

	// crc modes and polynomials
	localparam logic [2:0] CRC_NONE = 3'h0;
	localparam logic [2:0] CRC_P8 = 3'h1;
	localparam logic [2:0] CRC_P16A = 3'h2;
	localparam logic [2:0] CRC_P16B = 3'h3;
	localparam logic [2:0] CRC_P24 = 3'h4;
	localparam logic [2:0] CRC_P32 = 3'h5;
	localparam logic [35:0] POLY_P8 = 36'h000000007;
	localparam logic [35:0] POLY_P16A = 36'h000008005;
	localparam logic [35:0] POLY_P16B = 36'h000001021;
	localparam logic [35:0] POLY_P24 = 36'h000864CBF;
	localparam logic [35:0] POLY_P32 = 36'h04C011BB7;
	localparam logic [5:0] WID_P8 = 6'h08;
	localparam logic [5:0] WID_P16 = 6'h10;
	localparam logic [5:0] WID_P24 = 6'h18;
	localparam logic [5:0] WID_P32 = 6'h20;

	// decoded framing configuration
	typedef struct packed {
		logic [5:0] sync_bit_count;
		logic [9:0] preamble_pair_count;
		logic length_field_bytes;
		logic address_field_include;
		logic [1:0] frame_format;
		logic [1:0] rx_path;
		logic four_level_symbol_map_swap;
		logic lsb_first;
		logic [1:0] preamble_pattern;
		logic frame_check_type_hdr;
		logic fec_recursive;
		logic interleave_enable;
		logic uart_stop_level;
		logic uart_start_level;
		logic three_of_six_enable;
		logic manchester_enable;
		logic length_mode_variable;
		logic crc_enable;
		logic [5:0] crc_width;
		logic [35:0] crc_poly;
	} pfc_cfg_type;

endpackage

/* File: tb/pfc_remote_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// remote receiver model
// ****************************************
module pfc_remote_model (
	input wire pfc_pkg::pfc_cfg_type cfg_i,
	output logic [11:0] hdr_bits_o
);
	// bits the far end expects ahead of the payload
	always_comb begin
		hdr_bits_o = {1'b0, cfg_i.preamble_pair_count, 1'b0} + 12'(cfg_i.sync_bit_count);
		if (cfg_i.length_mode_variable) begin
			hdr_bits_o = hdr_bits_o + (cfg_i.length_field_bytes ? 12'h010 : 12'h008);
		end
		if (cfg_i.address_field_include) begin
			hdr_bits_o = hdr_bits_o + 12'h008;
		end
	end
endmodule // pfc_remote_model
`default_nettype wire

/* File: tb/test_packet_format_config.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// packet format configuration bench
// ****************************************
module test_packet_format_config;
	logic ref_clk_i;
	logic rst_b_i;
	logic [7:0] addr;
	logic wr_en;
	logic [7:0] wdata;
	logic rd_en;
	logic [7:0] rdata;
	logic rvalid;
	pfc_pkg::pfc_cfg_type cfg;
	logic len_err;
	logic [11:0] hdr_bits;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [7:0] rst_tab [6] = '{8'h80, 8'h10, 8'h00, 8'h20, 8'h00, 8'h2C};
	logic [7:0] msk_tab [6] = '{8'hFF, 8'hFF, 8'h88, 8'hFF, 8'h3F, 8'hFF};
	logic [35:0] poly_tab [8] = '{36'h0, 36'h7, 36'h8005, 36'h1021, 36'h864CBF, 36'h04C011BB7, 36'h0, 36'h0};
	logic [5:0] wid_tab [8] = '{6'h00, 6'h08, 6'h10, 6'h10, 6'h18, 6'h20, 6'h00, 6'h00};
	logic [7:0] f2e [3] = '{8'h2D, 8'h12, 8'hF7};

	pfc_top i_dut (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.reg_addr_i(addr),
		.reg_wr_i(wr_en),
		.reg_wdata_i(wdata),
		.reg_rd_i(rd_en),
		.reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid),
		.cfg_o(cfg),
		.length_cfg_error_o(len_err)
	);

	pfc_remote_model i_remote (
		.cfg_i(cfg),
		.hdr_bits_o(hdr_bits)
	);

	// clock
	always #50 ref_clk_i = ~ref_clk_i;

	// hang guard
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one write strobe, then one idle edge before the next request
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge ref_clk_i);
		wr_en = 1'b0;
		@(negedge ref_clk_i);
	endtask

	// write, then let the decoded config settle
	task automatic wrs(input logic [7:0] a, input logic [7:0] d);
		wr(a, d);
		repeat (2) @(negedge ref_clk_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		rd_en = 1'b1;
		@(negedge ref_clk_i);
		rd_en = 1'b0;
		chk("rvalid", 36'h1, {35'h0, rvalid});
		chk("rdata", {28'h0, exp}, {28'h0, rdata});
		@(negedge ref_clk_i);
	endtask

	// main sequence
	initial begin
		ref_clk_i = 1'b0;
		rst_b_i = 1'b0;
		addr = 8'h00;
		wr_en = 1'b0;
		wdata = 8'h00;
		rd_en = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		rst_b_i = 1'b1;
		@(negedge ref_clk_i);
		for (int i = 0; i < 6; i++) rd(8'h2B + 8'(i), rst_tab[i]);
		chk("preamble", 36'h010, {26'h0, cfg.preamble_pair_count});
		chk("sync", 36'h20, {30'h0, cfg.sync_bit_count});
		chk("rx_path", 36'h2, {34'h0, cfg.rx_path});
		chk("crc_poly", 36'h7, cfg.crc_poly);
		// reserved bits and unmapped offsets
		for (int i = 0; i < 6; i++) wr(8'h2B + 8'(i), 8'hFF);
		for (int i = 0; i < 6; i++) rd(8'h2B + 8'(i), msk_tab[i]);
		rd(8'h31, 8'h00);
		rd(8'h2A, 8'h00);
		@(negedge ref_clk_i);
		chk("rvalid idle", 36'h0, {35'h0, rvalid});
		chk("rdata idle", 36'h0, {28'h0, rdata});
		for (int i = 0; i < 6; i++) wr(8'h2B + 8'(i), 8'h00);
		// preamble, sync and length options seen by the far end
		wr(8'h2B, 8'hFE);
		wrs(8'h2C, 8'h34);
		chk("preamble", 36'h234, {26'h0, cfg.preamble_pair_count});
		chk("sync", 36'h3F, {30'h0, cfg.sync_bit_count});
		wrs(8'h2F, 8'h01);
		chk("len_err", 36'h1, {35'h0, len_err});
		chk("hdr", 36'h4AF, {24'h0, hdr_bits});
		wrs(8'h2D, 8'h88);
		chk("len_err", 36'h0, {35'h0, len_err});
		chk("len_bytes", 36'h1, {35'h0, cfg.length_field_bytes});
		chk("address", 36'h1, {35'h0, cfg.address_field_include});
		chk("hdr", 36'h4BF, {24'h0, hdr_bits});
		// frame formats and the mode-shared bits
		for (int f = 0; f < 4; f++) begin
			for (int b = 0; b < 2; b++) begin
				wr(8'h2E, {2'(f), 6'h00});
				wrs(8'h2F, b ? 8'h10 : 8'h08);
				chk("format", 36'(f), {34'h0, cfg.frame_format});
				chk("fec", 36'(f == 1 && b == 1), {35'h0, cfg.fec_recursive});
				chk("interleave", 36'(f == 1 && b == 0), {35'h0, cfg.interleave_enable});
				chk("stop", 36'(f == 2 && b == 1), {35'h0, cfg.uart_stop_level});
				chk("start", 36'(f == 2 && b == 0), {35'h0, cfg.uart_start_level});
			end
		end
		// receive path, symbol map, bit order, preamble pattern
		for (int i = 0; i < 3; i++) begin
			wrs(8'h2E, f2e[i]);
			chk("rx_path", {34'h0, f2e[i][5:4]}, {34'h0, cfg.rx_path});
			chk("swap", {35'h0, f2e[i][3]}, {35'h0, cfg.four_level_symbol_map_swap});
			chk("lsb_first", {35'h0, f2e[i][2]}, {35'h0, cfg.lsb_first});
			chk("pattern", {34'h0, f2e[i][1:0]}, {34'h0, cfg.preamble_pattern});
		end
		// line coding options
		for (int i = 0; i < 2; i++) begin
			wrs(8'h2F, i ? 8'h04 : 8'h26);
			chk("fcs_type", 36'(i == 0), {35'h0, cfg.frame_check_type_hdr});
			chk("three_of_six", 36'h1, {35'h0, cfg.three_of_six_enable});
			chk("manchester", 36'(i == 0), {35'h0, cfg.manchester_enable});
			chk("var_len", 36'h0, {35'h0, cfg.length_mode_variable});
		end
		// every crc code
		for (int m = 0; m < 8; m++) begin
			wrs(8'h30, {3'(m), 5'h0C});
			chk("crc_en", 36'(m >= 1 && m <= 5), {35'h0, cfg.crc_enable});
			chk("crc_width", {30'h0, wid_tab[m]}, {30'h0, cfg.crc_width});
			chk("crc_poly", poly_tab[m], cfg.crc_poly);
		end
		// reset in mid-run clears outputs and restores defaults
		wr(8'h2D, 8'h00);
		wrs(8'h2F, 8'h01);
		chk("len_err", 36'h1, {35'h0, len_err});
		rst_b_i = 1'b0;
		@(negedge ref_clk_i);
		chk("len_err_rst", 36'h0, {35'h0, len_err});
		chk("preamble_rst", 36'h0, {26'h0, cfg.preamble_pair_count});
		chk("rvalid_rst", 36'h0, {35'h0, rvalid});
		rst_b_i = 1'b1;
		@(negedge ref_clk_i);
		chk("preamble_dflt", 36'h010, {26'h0, cfg.preamble_pair_count});
		chk("crc_poly_dflt", 36'h7, cfg.crc_poly);
		rd(8'h2E, 8'h20);
		rd(8'h2F, 8'h00);
		report_and_stop();
	end
endmodule // test_packet_format_config
`default_nettype wire
